// ==== irq_status_defs.vh ====
/*
 * Constants for the interrupt and startup status block: register addresses,
 * serial frame fields, flag positions and reset values.
 * Assumes inclusion by bare name from the design files of this folder.
 */
`ifndef IRQ_STATUS_DEFS_VH
`define IRQ_STATUS_DEFS_VH

`define ADDR_CONFIG 4'h2
`define ADDR_OSC_TRIM 4'h3
`define ADDR_WATCHDOG 4'h4
`define ADDR_IRQ_ENABLE 4'h5
`define ADDR_IRQ_FLAG 4'h6
`define ADDR_STARTUP_STATUS 4'hF

`define FRAME_BITS 5'h18
`define FRAME_CNT_MAX 5'h1F
`define FRM_WRITE 23
`define FRM_CLEAR 22
`define FRM_ADDR_HI 21
`define FRM_ADDR_LO 18
`define FRM_DATA_HI 7
`define FRM_DATA_LO 0

`define SERIAL_ERR_BIT 7
`define AUTORESET_BIT 0
`define CAUSE_HI 5
`define CAUSE_AFTER_ACK 6'h01

`define RST_BYTE 8'h00
`define RST_CAUSE 6'h00
`define RST_TRIM 5'h00
`define RST_ADDR 4'h0
`define TQ_BASE_CYCLES 8'h64

`endif

// ==== serial_frame_engine.v ====
/*
 * Serial slave framing: synchronises the serial pins, collects a 24-bit
 * frame MSB first, and shifts a reply byte out during the frame.
 * Assumes the host keeps the serial clock well below sys_clk / 4.
 */
`include "irq_status_defs.vh"

module serial_frame_engine (
  input wire sys_clk,
  input wire nrst,
  input wire sclk,
  input wire sin,
  input wire cs_n,
  input wire [7:0] load_data,
  output reg sout,
  output reg frame_start,
  output reg frame_done,
  output reg frame_error,
  output reg [23:0] frame_word
);

  reg sclk_s1, sclk_s2, sclk_d;
  reg sin_s1, sin_s2;
  reg cs_s1, cs_s2, cs_d;
  reg [23:0] in_shift;
  reg [7:0] out_shift;
  reg [4:0] bit_cnt;

  wire sclk_rise = sclk_s2 & ~sclk_d;
  wire sclk_fall = ~sclk_s2 & sclk_d;
  wire cs_fall = ~cs_s2 & cs_d;
  wire cs_rise = cs_s2 & ~cs_d;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers, then a delayed copy for edge detection
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      sin_s1 <= 1'b0;
      sin_s2 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      sin_s1 <= sin;
      sin_s2 <= sin_s1;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame collection and reply shifting
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      in_shift <= 24'h000000;
      out_shift <= `RST_BYTE;
      bit_cnt <= 5'h00;
      sout <= 1'b0;
      frame_start <= 1'b0;
      frame_done <= 1'b0;
      frame_error <= 1'b0;
      frame_word <= 24'h000000;
    end else begin
      frame_start <= cs_fall;
      frame_done <= 1'b0;
      frame_error <= 1'b0;
      if (cs_fall) begin
        bit_cnt <= 5'h00;
        out_shift <= load_data;
        sout <= load_data[7];
      end else if (!cs_s2) begin
        if (sclk_rise) begin
          in_shift <= {in_shift[22:0], sin_s2};
          if (bit_cnt != `FRAME_CNT_MAX)
            bit_cnt <= bit_cnt + 5'h01;
        end
        if (sclk_fall) begin
          out_shift <= {out_shift[6:0], 1'b0};
          sout <= out_shift[6];
        end
      end
      if (cs_rise) begin
        // A short or long frame is discarded: frame_error pulses instead of frame_done
        if (bit_cnt == `FRAME_BITS) begin
          frame_done <= 1'b1;
          frame_word <= in_shift;
        end else begin
          frame_error <= 1'b1;
        end
      end
    end
  end

endmodule // serial_frame_engine

// ==== interrupt_and_startup_status.v ====
/*
 * Interrupt flag, enable and startup status registers of a system-basis
 * chip, reached over the serial register interface, with the interrupt
 * request pin and an oscillator-trimmed time quantum tick.
 * Assumes event inputs are single-cycle pulses on sys_clk and that the
 * reset output and startup cause come from logic on the same clock.
 */
// Functional notes
// - Startup cause after reset-output low is readable in six low status bits.
// - Cause bits hold until first watchdog acknowledge, then become 000001.
// - Every flag is gated by its enable bit except the serial error flag.
// - Interrupt line stays low while an enabled flag is set, until cleared.
// - With autoreset selected, reading the flags clears all of them.
// - Time quantum length comes from the oscillator and follows its trim value.
// - Flags clear by explicit write or the serial clear-register operation.
// - Flag register sits at address 6, after enable register at 5.
`include "irq_status_defs.vh"

module interrupt_and_startup_status #(
  parameter FLAG_WIDTH = 8
) (
  input wire sys_clk,
  input wire nrst,
  input wire sclk,
  input wire sin,
  input wire cs_n,
  input wire [FLAG_WIDTH-1:0] flag_events,
  input wire reset_output_n,
  input wire [5:0] startup_cause,
  output reg sout,
  output reg interrupt_request_n,
  output reg tq_tick
);

  reg [7:0] interrupt_flag_reg;
  reg [7:0] interrupt_enable_reg;
  reg [7:0] config_reg;
  reg [4:0] oscillator_trim_reg;
  reg [7:0] watchdog_control_reg;
  reg [5:0] system_startup_status;
  reg [3:0] read_addr;
  reg rst_out_d;
  reg [7:0] tq_cnt;
  reg [7:0] next_flags;
  reg [7:0] flag_clr;

  wire sout_w;
  wire frame_start;
  wire frame_done;
  wire frame_error;
  wire [23:0] frame_word;
  wire [3:0] f_addr = frame_word[`FRM_ADDR_HI:`FRM_ADDR_LO];
  wire [7:0] f_data = frame_word[`FRM_DATA_HI:`FRM_DATA_LO];
  wire f_write = frame_done & frame_word[`FRM_WRITE];
  wire f_clear = frame_done & frame_word[`FRM_CLEAR];

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux; unmapped addresses read as zero
  function [7:0] read_mux;
    input [3:0] addr;
    begin
      if (addr == `ADDR_CONFIG)
        read_mux = config_reg;
      else if (addr == `ADDR_OSC_TRIM)
        read_mux = {3'h0, oscillator_trim_reg};
      else if (addr == `ADDR_WATCHDOG)
        read_mux = watchdog_control_reg;
      else if (addr == `ADDR_IRQ_ENABLE)
        read_mux = interrupt_enable_reg;
      else if (addr == `ADDR_IRQ_FLAG)
        read_mux = interrupt_flag_reg;
      else if (addr == `ADDR_STARTUP_STATUS)
        read_mux = {2'h0, system_startup_status};
      else
        read_mux = 8'h00;
    end
  endfunction

  // Frame decode: a strobe qualified by one register address
  function hit;
    input strobe;
    input [3:0] addr;
    input [3:0] target;
    begin
      hit = strobe & (addr == target);
    end
  endfunction

  wire wr_config = hit(f_write, f_addr, `ADDR_CONFIG);
  wire wr_trim = hit(f_write, f_addr, `ADDR_OSC_TRIM);
  wire wr_watchdog = hit(f_write, f_addr, `ADDR_WATCHDOG);
  wire wr_enable = hit(f_write, f_addr, `ADDR_IRQ_ENABLE);
  wire wr_flags = hit(f_write, f_addr, `ADDR_IRQ_FLAG);
  wire clr_enable = hit(f_clear, f_addr, `ADDR_IRQ_ENABLE);
  wire clr_flags = hit(f_clear, f_addr, `ADDR_IRQ_FLAG);

  // Reply is the register named by the previous frame, loaded at frame start
  wire [7:0] reply = read_mux(read_addr);
  wire flag_read = frame_start & (read_addr == `ADDR_IRQ_FLAG);

  serial_frame_engine u_serial (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sclk(sclk),
    .sin(sin),
    .cs_n(cs_n),
    .load_data(reply),
    .sout(sout_w),
    .frame_start(frame_start),
    .frame_done(frame_done),
    .frame_error(frame_error),
    .frame_word(frame_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flag update: a set in the clearing cycle wins over the clear
  always @* begin
    flag_clr = 8'h00;
    if (wr_flags)
      flag_clr = f_data;
    if (clr_flags)
      flag_clr = 8'hFF;
    if (flag_read && config_reg[`AUTORESET_BIT])
      flag_clr = 8'hFF;
    next_flags = (interrupt_flag_reg & ~flag_clr) | flag_events[7:0];
    if (frame_error)
      next_flags[`SERIAL_ERR_BIT] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers, one process each; rst_out_d shares the startup status process
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_flag_reg <= `RST_BYTE;
    end else begin
      interrupt_flag_reg <= next_flags;
    end
  end

  // Any valid frame, write or not, names the next reply
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      read_addr <= `RST_ADDR;
    end else if (frame_done) begin
      read_addr <= f_addr;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_enable_reg <= `RST_BYTE;
    end else if (wr_enable) begin
      interrupt_enable_reg <= f_data;
    end else if (clr_enable) begin
      interrupt_enable_reg <= `RST_BYTE;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      config_reg <= `RST_BYTE;
    end else if (wr_config) begin
      config_reg <= f_data;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      oscillator_trim_reg <= `RST_TRIM;
    end else if (wr_trim) begin
      oscillator_trim_reg <= f_data[4:0];
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_control_reg <= `RST_BYTE;
    end else if (wr_watchdog) begin
      watchdog_control_reg <= f_data;
    end
  end

  // Cause caught as the reset output releases; any watchdog write acknowledges
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_out_d <= 1'b0;
      system_startup_status <= `RST_CAUSE;
    end else begin
      rst_out_d <= reset_output_n;
      if (reset_output_n && !rst_out_d)
        system_startup_status <= startup_cause;
      else if (wr_watchdog)
        system_startup_status <= `CAUSE_AFTER_ACK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt line: registered so it never glitches on the pin
  wire [7:0] gate = {1'b1, interrupt_enable_reg[6:0]};
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_request_n <= 1'b1;
      sout <= 1'b0;
    end else begin
      interrupt_request_n <= ~|(interrupt_flag_reg & gate);
      sout <= sout_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time quantum: period moves with the signed trim, like the RC oscillator
  wire [7:0] trim_ext = {{3{oscillator_trim_reg[4]}}, oscillator_trim_reg};
  wire [7:0] tq_period = `TQ_BASE_CYCLES - trim_ext;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tq_cnt <= 8'h00;
      tq_tick <= 1'b0;
    end else begin
      tq_tick <= 1'b0;
      if (tq_cnt >= tq_period - 8'h01) begin
        tq_cnt <= 8'h00;
        tq_tick <= 1'b1;
      end else begin
        tq_cnt <= tq_cnt + 8'h01;
      end
    end
  end

endmodule // interrupt_and_startup_status

// ==== irq_status_asserts.sv ====
/* Port assertions for the interrupt and status block.
   Assumes flag pulses come over 8 cycles clear of any frame. */
module irq_status_asserts #(
  parameter FLAG_WIDTH = 8
) (
  input wire sys_clk,
  input wire nrst,
  input wire cs_n,
  input wire [FLAG_WIDTH-1:0] flag_events,
  input wire sout,
  input wire interrupt_request_n,
  input wire tq_tick
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic [7:0] since_cs;
  logic [7:0] tq_cnt;
  logic ticked;
  // Saturating, so long idle spans never wrap
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      since_cs <= 8'hFF;
      tq_cnt <= 8'h00;
      ticked <= 1'b0;
    end else begin
      since_cs <= !cs_n ? 8'h00 : since_cs + {7'h00, since_cs != 8'hFF};
      tq_cnt <= tq_tick ? 8'h00 : tq_cnt + {7'h00, tq_cnt != 8'hFF};
      ticked <= ticked | tq_tick;
    end
  end
  ////////////////////////////////////////
  property p_err_low; flag_events[7] |-> ##2 !interrupt_request_n; endproperty
  a_err_low: assert property (p_err_low) else $error("irq not low");
  property p_err_hold; flag_events[7] && since_cs > 8'h08 |-> ##2 (!interrupt_request_n) [*3]; endproperty
  a_err_hold: assert property (p_err_hold) else $error("irq not held");
  property p_release; $rose(interrupt_request_n) |-> since_cs < 8'h0C; endproperty
  a_release: assert property (p_release) else $error("irq freed alone");
  property p_fall; $fell(interrupt_request_n) |-> (|$past(flag_events, 2)) || since_cs < 8'h0C; endproperty
  a_fall: assert property (p_fall) else $error("irq fell alone");
  property p_rst_high; !$past(nrst) |-> interrupt_request_n; endproperty
  a_rst_high: assert property (p_rst_high) else $error("irq low at reset");
  property p_tick_pulse; tq_tick |=> !tq_tick; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
  property p_tick_span; tq_tick && ticked && since_cs == 8'hFF |-> tq_cnt >= 8'h53 && tq_cnt <= 8'h73; endproperty
  a_tick_span: assert property (p_tick_span) else $error("tick span");
  property p_sout_idle; cs_n && since_cs == 8'hFF |-> $stable(sout); endproperty
  a_sout_idle: assert property (p_sout_idle) else $error("sout moved");
  c_irq: cover property ($fell(interrupt_request_n));
  c_tick: cover property (tq_tick && ticked);
  c_frame: cover property ($rose(cs_n));
endmodule // irq_status_asserts
bind interrupt_and_startup_status irq_status_asserts #(.FLAG_WIDTH(FLAG_WIDTH)) u_chk (.sys_clk(sys_clk),
  .nrst(nrst), .cs_n(cs_n), .flag_events(flag_events), .sout(sout), .interrupt_request_n(interrupt_request_n),
  .tq_tick(tq_tick));

// ==== serial_host.sv ====
/* Host side of the serial register link: frames out MSB first, reply in.
   Assumes sys_clk is the device clock; sclk half period is 6 cycles. */
module serial_host (
  input wire sys_clk,
  input wire sout,
  output logic sclk,
  output logic sin,
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    sin = 1'b0;
    cs_n = 1'b1;
  end
  // Read, write and clear-register frames; short counts only to provoke refusal
  task automatic xfer(input logic [23:0] w, input int n, output logic [7:0] rd);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sin = w[23-i];
      repeat (6) @(negedge sys_clk);
      if (i < 8) rd[7-i] = sout;
      sclk = 1'b1;
      repeat (6) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (2) @(negedge sys_clk);
    cs_n = 1'b1;
    // Released line must not look like held data
    sin = ~sin;
    repeat (10) @(negedge sys_clk);
  endtask
endmodule // serial_host

// ==== tb_top.sv ====
/* Self-checking bench for the interrupt and status block.
   Assumes the host model of serial_host.sv. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] flag_events = 8'h00;
  logic reset_output_n = 1'b0;
  logic [5:0] startup_cause = 6'h2A;
  wire sclk, sin, cs_n, sout, interrupt_request_n, tq_tick;
  logic [7:0] rd;
  int n_fail = 0;
  int n_checks = 0;
  // Event mask, enable mask, expected request level
  logic [19:0] rows [5] = '{20'h01001, 20'h01010, 20'h80000, 20'h047F0, 20'h40BF1};
  always #50 sys_clk = ~sys_clk;
  interrupt_and_startup_status u_dut (.sys_clk(sys_clk), .nrst(nrst), .sclk(sclk), .sin(sin), .cs_n(cs_n),
    .flag_events(flag_events), .reset_output_n(reset_output_n), .startup_cause(startup_cause), .sout(sout),
    .interrupt_request_n(interrupt_request_n), .tq_tick(tq_tick));
  serial_host u_host (.sys_clk(sys_clk), .sout(sout), .sclk(sclk), .sin(sin), .cs_n(cs_n));
  ////////////////////////////////////////
  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic irq_is(input logic e);
    chk("irq", {7'h00, e}, {7'h00, interrupt_request_n});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_host.xfer({2'b10, a, 10'h000, d}, 24, rd);
  endtask
  // Reply is pipelined: the second frame returns what the first addressed
  task automatic rdr(input logic [3:0] a, input logic [7:0] e);
    u_host.xfer({2'b00, a, 18'h00000}, 24, rd);
    u_host.xfer({2'b00, a, 18'h00000}, 24, rd);
    chk("read", e, rd);
  endtask
  task automatic pulse(input logic [7:0] m);
    flag_events = m;
    @(negedge sys_clk) flag_events = 8'h00;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic period(input logic [4:0] t, input logic [7:0] e);
    int c;
    wr(4'h3, {3'h0, t});
    repeat (300) @(negedge sys_clk);
    for (c = 0; c < 200 && tq_tick !== 1'b1; c++) @(negedge sys_clk);
    @(negedge sys_clk);
    for (c = 1; c < 200 && tq_tick !== 1'b1; c++) @(negedge sys_clk);
    chk("period", e, c[7:0]);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    irq_is(1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(4'h5, rows[i][11:4]);
      pulse(rows[i][19:12]);
      irq_is(rows[i][0]);
      wr(4'h6, 8'hFF);
      irq_is(1'b1);
    end
    reset_output_n = 1'b1;
    rdr(4'hF, 8'h2A);
    wr(4'h4, 8'h00);
    rdr(4'hF, 8'h01);
    pulse(8'h10);
    rdr(4'h6, 8'h10);
    rdr(4'h5, 8'hBF);
    irq_is(1'b0);
    u_host.xfer({2'b01, 4'h6, 18'h00000}, 24, rd);
    irq_is(1'b1);
    wr(4'h2, 8'h01);
    pulse(8'h03);
    rdr(4'h6, 8'h03);
    rdr(4'h6, 8'h00);
    wr(4'h2, 8'h00);
    u_host.xfer(24'h000000, 23, rd);
    irq_is(1'b0);
    wr(4'h5, 8'h00);
    irq_is(1'b0);
    rdr(4'h6, 8'h80);
    wr(4'h6, 8'h80);
    irq_is(1'b1);
    period(5'h0A, 8'h5A);
    period(5'h10, 8'h74);
    pulse(8'h80);
    nrst = 1'b0;
    @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    irq_is(1'b1);
    give_verdict;
  end
  // About four times the expected run
  initial begin
    #4_000_000;
    n_fail++;
    give_verdict;
  end
endmodule // tb_top
